/* rtl/daqsc_top.sv */
/*
  Sequencer, calibration engine, correction unit, limit monitor, result store
  and instruction store of the data acquisition converter.
  Assumes the comparator and bus-width pins are asynchronous and a host that
  uses one-cycle read and write strobes on the register port.
*/
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Three modes: 12-bit, 8-bit, limit monitor
// - Results are two's-complement signed values
// - One comparison per result bit
// - Offset once or eight times averaged
// - Each capacitor measured eight times, thirteen coefficients
// - Calibration steps through 16x8 pattern store
// - 12-bit results get offset and linearity correction
// - 8-bit and monitor modes use offset only
// - 8-bit conversion under half 12-bit time
// - Two limits flag above or below events
// - Acquisition time 1.5 to 6.5 microseconds
// - Store up to 32 results unattended
// - Flag when store full or threshold reached
// - Host reads store anytime, results in order
// - Diagnostic bit 11 routes references to input
// - Eight instructions, three 16-bit sections each
// - Instruction address from WORD_ADDRESS_LINES or A4-A0
// - Instructions reachable in any order
// - Config bits 9:8 select instruction section
// - Section 0 control, section 1 limit one
// - Last-instruction flag wraps to instruction 0
// - Writing start bit restarts sequencer
// - Section 0 bit 10 selects resolution
module daqsc_top
	import daqsc_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Register port
	input wire logic [4:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdData,
	// Bus width pin, high for 8-bit bus
	input wire logic bus_width_select,
	// Converter analog front end
	input wire logic compIn,
	output logic [12:0] dacCode,
	output logic shHold,
	output logic [2:0] muxPos,
	output logic [2:0] muxNeg,
	output logic diagRoute,
	output logic calActive,
	output logic calOffsetSel,
	output logic [3:0] calCapSel,
	// Sticky event flags
	output logic [5:0] eventFlags
);
	// Pin synchronisers
	logic bwSync1_reg, bwSync2_reg, compSync1_reg, compSync2_reg;
	// Configuration, status, threshold
	logic [15:0] cfgReg;
	logic [5:0] stReg;
	logic [5:0] threshReg;
	logic diagReg;
	// Instruction store: three sections of eight entries
	logic [15:0] instrMem [0:23];
	// Result store
	logic [15:0] fifoMem [0:31];
	logic [4:0] wrPtrReg, rdPtrReg;
	logic [5:0] fifoCount;
	// Sequencer state
	daqsc_state_t stateReg;
	logic [2:0] pcReg;
	logic [6:0] cntReg;
	logic [3:0] trialReg;
	logic [12:0] sarReg;
	logic [12:0] dacReg;
	logic firstRunReg, res8Reg, wdogReg, holdReg;
	logic [2:0] posReg, negReg;
	// Correction unit
	logic signed [15:0] aluAcc;
	logic [3:0] aluBit;
	logic aluInit;
	// Calibration engine
	logic calRunReg;
	logic [3:0] romIdxReg;
	logic [2:0] calRepReg;
	logic signed [15:0] calSum;
	logic calOff_reg; // High while the offset step runs
	logic signed [11:0] offCoef;
	logic signed [11:0] linCoef [0:LIN_CNT-1];
	logic [15:0] rdDataReg;

	// Address decode: 16-bit uses WORD_ADDRESS_LINES, 8-bit adds A0 as byte lane
	wire byteMode = bwSync2_reg;
	wire hiLane = byteMode & regAddr[0];
	wire [3:0] wordIdx = regAddr[4:1];
	wire isRam = ~regAddr[4];
	wire [1:0] ramPtr = cfgReg[CFG_PTR_LO+1:CFG_PTR_LO];
	wire [4:0] ramSel = {ramPtr, regAddr[3:1]};
	wire ramWr = regWr & isRam & (ramPtr != 2'h3);
	wire cfgWr = regWr & ~isRam & (wordIdx == W_CONFIG);
	wire stWr = regWr & ~isRam & (wordIdx == W_STATUS);
	wire thWr = regWr & ~isRam & (wordIdx == W_FIFOCTL);
	wire popReq = regRd & ~isRam & (wordIdx == W_FIFODATA) & ~hiLane;

	// Byte lane merge for writes in 8-bit mode
	function automatic logic [15:0] mergeWr(input logic [15:0] old);
		if (!byteMode)
			mergeWr = regWrData;
		else if (regAddr[0])
			mergeWr = {regWrData[7:0], old[7:0]};
		else
			mergeWr = {old[15:8], regWrData[7:0]};
	endfunction

	wire [15:0] cfgMerged = mergeWr(cfgReg);
	wire softRst = cfgWr & cfgMerged[CFG_RESET];

	// Current instruction fields
	wire [15:0] sec0 = instrMem[{2'h0, pcReg}];
	wire [15:0] sec1 = instrMem[{2'h1, pcReg}];
	wire [15:0] sec2 = instrMem[{2'h2, pcReg}];
	wire [3:0] acqCode = sec0[I_ACQ_LO+3:I_ACQ_LO];
	wire [6:0] acqRaw = 7'(ACQ_MIN_CYC + {acqCode, 2'b00});
	wire [6:0] acqCyc = (acqRaw > ACQ_MAX_CYC) ? ACQ_MAX_CYC : acqRaw;
	wire pauseHere = sec0[I_PAUSE] & ~firstRunReg;
	wire [6:0] trialCyc = res8Reg ? TRIAL_CYC_LO : TRIAL_CYC_HI;
	wire [3:0] lowBit = res8Reg ? LOW_BIT_LO : LOW_BIT_HI;
	wire [12:0] trialMask = 13'h0001 << trialReg;
	wire [12:0] sarNext = compSync2_reg ? (sarReg | trialMask) : sarReg;
	wire calReq = cfgReg[CFG_OFFCAL] | cfgReg[CFG_FULLCAL];

	// Raw offset-binary code to two's complement, then offset removed
	wire signed [15:0] rawSigned = 16'(signed'({~sarReg[12], sarReg[11:0]}));
	wire signed [15:0] offExt = calRunReg ? 16'h0000 : 16'(offCoef);
	wire signed [15:0] linExt = 16'(linCoef[aluBit]);

	// Limit comparison on the 9-bit result
	wire signed [8:0] sample9 = aluAcc[12:4];
	wire signed [8:0] lim1 = {sec1[LIM_SIGN], sec1[7:0]};
	wire signed [8:0] lim2 = {sec2[LIM_SIGN], sec2[7:0]};
	wire hit1 = sec1[LIM_DIR] ? (sample9 > lim1) : (sample9 < lim1);
	wire hit2 = sec2[LIM_DIR] ? (sample9 > lim2) : (sample9 < lim2);

	// Calibration bookkeeping
	wire [7:0] romWord = CAL_ROM[romIdxReg];
	wire [7:0] romNextWord = CAL_ROM[4'(romIdxReg + 4'h1)];
	wire [2:0] repLast = cfgReg[CFG_FULLCAL] ? CAL_AVG_LAST : 3'h0;
	wire signed [15:0] calTotal = 16'(calSum + aluAcc);
	wire [11:0] calAvg = cfgReg[CFG_FULLCAL] ? calTotal[14:3] : calTotal[11:0];
	wire repDone = (stateReg == S_CALSTEP) & (calRepReg == repLast);
	wire calFinish = repDone & (~cfgReg[CFG_FULLCAL] | romNextWord[ROM_END]);
	wire linWr = repDone & ~romWord[ROM_OFF];

	// Events
	wire pauseEvt = (stateReg == S_IDLE) & ~calReq & cfgReg[CFG_START] & pauseHere;
	wire storeEvt = (stateReg == S_STORE);
	wire pushReq = storeEvt & ~wdogReg & (fifoCount != FIFO_DEPTH);
	wire doPop = popReq & (fifoCount != 6'h00);
	wire [5:0] countNext = 6'(fifoCount + {5'h00, pushReq} - {5'h00, doPop});
	wire [5:0] stSet = {calFinish, pauseEvt,
		pushReq & (countNext == threshReg), pushReq & (countNext == FIFO_DEPTH),
		storeEvt & wdogReg & hit2, storeEvt & wdogReg & hit1};
	// Write-one-to-clear: the lane not written must clear nothing
	wire [15:0] stMerged = mergeWr(16'h0000);
	wire [15:0] thMerged = mergeWr({10'h000, threshReg});
	wire [5:0] stClr = stWr ? stMerged[5:0] : 6'h00;

	// Read mux
	wire [15:0] rdWord =
		isRam ? ((ramPtr == 2'h3) ? 16'h0000 : instrMem[ramSel]) :
		(wordIdx == W_CONFIG) ? (cfgReg & ~(16'h0001 << CFG_RESET)) :
		(wordIdx == W_STATUS) ? {9'h000, (stateReg != S_IDLE), stReg} :
		(wordIdx == W_FIFOCTL) ? {2'h0, fifoCount, 2'h0, threshReg} :
		(wordIdx == W_FIFODATA) ? fifoMem[rdPtrReg] :
		(wordIdx == W_OFFSET) ? 16'(offCoef) : 16'h0000;
	wire [15:0] rdLane = !byteMode ? rdWord : (regAddr[0] ? {8'h00, rdWord[15:8]} : {8'h00, rdWord[7:0]});

	// Pin synchronisers
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			bwSync1_reg <= 1'b0;
			bwSync2_reg <= 1'b0;
			compSync1_reg <= 1'b0;
			compSync2_reg <= 1'b0;
		end
		else
		begin
			bwSync1_reg <= bus_width_select;
			bwSync2_reg <= bwSync1_reg;
			compSync1_reg <= compIn;
			compSync2_reg <= compSync1_reg;
		end
	end

	// Configuration: software set wins over hardware clear
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			cfgReg <= CFG_RESET_VAL;
		else if (cfgWr)
			cfgReg <= cfgMerged & CFG_MASK;
		else
		begin
			if (pauseEvt)
				cfgReg[CFG_START] <= 1'b0;
			if (calFinish)
			begin
				cfgReg[CFG_OFFCAL] <= 1'b0;
				cfgReg[CFG_FULLCAL] <= 1'b0;
			end
		end
	end

	// Status flags, write one to clear, set wins; threshold; diagnostic route
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			stReg <= 6'h00;
			threshReg <= THRESH_RESET;
			diagReg <= 1'b0;
			rdDataReg <= 16'h0000;
		end
		else
		begin
			stReg <= (stReg & ~stClr) | stSet;
			if (thWr)
				threshReg <= thMerged[5:0];
			diagReg <= cfgReg[CFG_DIAG];
			rdDataReg <= regRd ? rdLane : 16'h0000;
		end
	end

	// Instruction store, one entry per section and address
	generate
		for (genvar gi = 0; gi < 24; gi++)
		begin : g_ram
			always_ff @(posedge clk_sys or posedge reset)
			begin
				if (reset)
					instrMem[gi] <= 16'h0000;
				else if (ramWr && ramSel == 5'(gi))
					instrMem[gi] <= mergeWr(instrMem[gi]);
			end
		end
	endgenerate

	// Linearity coefficients, one per ladder capacitor
	generate
		for (genvar gl = 0; gl < LIN_CNT; gl++)
		begin : g_lin
			always_ff @(posedge clk_sys or posedge reset)
			begin
				if (reset)
					linCoef[gl] <= 12'h000;
				else if (linWr && romWord[3:0] == 4'(gl))
					linCoef[gl] <= calAvg;
			end
		end
	endgenerate

	// Result store, read pops oldest entry
	always_ff @(posedge clk_sys)
	begin
		if (pushReq)
			fifoMem[wrPtrReg] <= aluAcc;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			wrPtrReg <= 5'h00;
			rdPtrReg <= 5'h00;
			fifoCount <= 6'h00;
		end
		else if (softRst)
		begin
			wrPtrReg <= 5'h00;
			rdPtrReg <= 5'h00;
			fifoCount <= 6'h00;
		end
		else
		begin
			if (pushReq)
				wrPtrReg <= 5'(wrPtrReg + 5'h01);
			if (doPop)
				rdPtrReg <= 5'(rdPtrReg + 5'h01);
			fifoCount <= countNext;
		end
	end

	// Sequencer, conversion, correction and calibration
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset || softRst)
		begin
			stateReg <= S_IDLE;
			pcReg <= 3'h0;
			cntReg <= 7'h00;
			trialReg <= 4'h0;
			sarReg <= 13'h0000;
			dacReg <= 13'h0000;
			firstRunReg <= 1'b1;
			res8Reg <= 1'b0;
			wdogReg <= 1'b0;
			holdReg <= 1'b0;
			posReg <= 3'h0;
			negReg <= 3'h0;
			aluAcc <= 16'sh0000;
			aluBit <= 4'h0;
			aluInit <= 1'b0;
			calRunReg <= 1'b0;
			romIdxReg <= 4'h0;
			calRepReg <= 3'h0;
			calSum <= 16'sh0000;
			offCoef <= 12'h000;
			calOff_reg <= 1'b0;
		end
		else
		begin
			dacReg <= (stateReg == S_SAR) ? (sarReg | trialMask) : 13'h0000;
			case (stateReg)
				S_IDLE:
				begin
					if (calReq)
					begin
						// Calibration runs the converter at full resolution
						calRunReg <= 1'b1;
						calOff_reg <= CAL_ROM[0][ROM_OFF];
						romIdxReg <= 4'h0;
						calRepReg <= 3'h0;
						calSum <= 16'sh0000;
						res8Reg <= 1'b0;
						wdogReg <= 1'b0;
						holdReg <= 1'b1;
						sarReg <= 13'h0000;
						trialReg <= TOP_BIT;
						cntReg <= 7'(TRIAL_CYC_HI - 7'h01);
						stateReg <= S_SAR;
					end
					else if (cfgReg[CFG_START] && pauseHere)
						firstRunReg <= 1'b1; // Stop before executing; restart overrides
					else if (cfgReg[CFG_START])
					begin
						firstRunReg <= 1'b0;
						res8Reg <= sec0[I_RES8] | sec0[I_WDOG];
						wdogReg <= sec0[I_WDOG];
						posReg <= sec0[I_POS_LO+2:I_POS_LO];
						negReg <= sec0[I_NEG_LO+2:I_NEG_LO];
						holdReg <= 1'b0;
						cntReg <= 7'(acqCyc - 7'h01);
						stateReg <= S_ACQ;
					end
				end
				S_ACQ:
				begin
					if (cntReg == 7'h00)
					begin
						holdReg <= 1'b1;
						sarReg <= 13'h0000;
						trialReg <= TOP_BIT;
						cntReg <= 7'(trialCyc - 7'h01);
						stateReg <= S_SAR;
					end
					else
						cntReg <= 7'(cntReg - 7'h01);
				end
				S_SAR:
				begin
					if (cntReg == 7'h00)
					begin
						sarReg <= sarNext;
						if (trialReg == lowBit)
						begin
							aluInit <= 1'b1;
							aluBit <= TOP_BIT;
							stateReg <= S_ALU;
						end
						else
						begin
							trialReg <= 4'(trialReg - 4'h1);
							cntReg <= 7'(trialCyc - 7'h01);
						end
					end
					else
						cntReg <= 7'(cntReg - 7'h01);
				end
				S_ALU:
				begin
					if (aluInit)
					begin
						aluInit <= 1'b0;
						aluAcc <= 16'(rawSigned - offExt);
						if (calRunReg)
							stateReg <= S_CALSTEP;
						else if (res8Reg)
							stateReg <= S_STORE;
					end
					else
					begin
						if (sarReg[aluBit])
							aluAcc <= 16'(aluAcc - linExt);
						if (aluBit == 4'h0)
							stateReg <= S_STORE;
						else
							aluBit <= 4'(aluBit - 4'h1);
					end
				end
				S_STORE:
				begin
					holdReg <= 1'b0;
					if (sec0[I_LOOP] || pcReg == LAST_INSTR)
						pcReg <= 3'h0;
					else
						pcReg <= 3'(pcReg + 3'h1);
					stateReg <= S_IDLE;
				end
				S_CALSTEP:
				begin
					sarReg <= 13'h0000;
					trialReg <= TOP_BIT;
					cntReg <= 7'(TRIAL_CYC_HI - 7'h01);
					if (repDone)
					begin
						if (romWord[ROM_OFF])
							offCoef <= calAvg;
						calSum <= 16'sh0000;
						calRepReg <= 3'h0;
						romIdxReg <= 4'(romIdxReg + 4'h1);
						calOff_reg <= romNextWord[ROM_OFF] & ~calFinish;
						if (calFinish)
						begin
							calRunReg <= 1'b0;
							holdReg <= 1'b0;
							stateReg <= S_IDLE;
						end
						else
							stateReg <= S_SAR;
					end
					else
					begin
						calSum <= calTotal;
						calRepReg <= 3'(calRepReg + 3'h1);
						stateReg <= S_SAR;
					end
				end
				default:
					stateReg <= S_IDLE;
			endcase
		end
	end

	// Outputs straight from flops
	assign regRdData = rdDataReg;
	assign dacCode = dacReg;
	assign shHold = holdReg;
	assign muxPos = posReg;
	assign muxNeg = negReg;
	assign diagRoute = diagReg;
	assign calActive = calRunReg;
	assign calOffsetSel = calOff_reg;
	assign calCapSel = romIdxReg;
	assign eventFlags = stReg;

	// Helper counters for timing checks
	logic [7:0] convLen;
	logic [7:0] acqLen;
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			convLen <= 8'h00;
			acqLen <= 8'h00;
		end
		else
		begin
			convLen <= (stateReg == S_SAR || stateReg == S_ALU) ? 8'(convLen + 8'h01) : 8'h00;
			acqLen <= (stateReg == S_ACQ) ? 8'(acqLen + 8'h01) : 8'h00;
		end
	end

	localparam int HALF_HI = 39;
	sequence sAcqEnd;
		(stateReg == S_ACQ) && (cntReg == 7'h00);
	endsequence
	sequence sSarBegin;
		(stateReg == S_SAR) && holdReg && (trialReg == TOP_BIT);
	endsequence

	a_acq_window: assert property (@(posedge clk_sys) disable iff (reset)
		sAcqEnd |-> (acqLen >= 8'(ACQ_MIN_CYC - 7'h01)) && (acqLen < 8'(ACQ_MAX_CYC)))
		else $error("acquisition length outside range");
	a_acq_to_sar: assert property (@(posedge clk_sys) disable iff (reset)
		sAcqEnd ##1 sSarBegin |-> ##[1:100] (stateReg == S_ALU))
		else $error("conversion did not reach correction");
	a_lo_res_time: assert property (@(posedge clk_sys) disable iff (reset)
		(stateReg == S_STORE) && res8Reg |-> (convLen < 8'(HALF_HI)))
		else $error("8-bit conversion too slow");
	a_lo_offset_only: assert property (@(posedge clk_sys) disable iff (reset)
		(stateReg == S_ALU) && aluInit && res8Reg && !calRunReg |=> (stateReg == S_STORE))
		else $error("linearity applied in 8-bit mode");
	a_loop_wrap: assert property (@(posedge clk_sys) disable iff (reset)
		(stateReg == S_STORE) && sec0[I_LOOP] && !softRst |=> (pcReg == 3'h0))
		else $error("loop flag did not wrap");
	a_start_set: assert property (@(posedge clk_sys) disable iff (reset)
		cfgWr && !byteMode && regWrData[CFG_START] && !regWrData[CFG_RESET] |=> cfgReg[CFG_START])
		else $error("start bit not taken");
	a_fifo_bound: assert property (@(posedge clk_sys) disable iff (reset)
		fifoCount <= FIFO_DEPTH)
		else $error("result store overfilled");
	a_fifo_order: assert property (@(posedge clk_sys) disable iff (reset)
		doPop && !byteMode |=> (regRdData == $past(fifoMem[rdPtrReg])))
		else $error("result read out of order");
	a_full_flag: assert property (@(posedge clk_sys) disable iff (reset)
		pushReq && (countNext == FIFO_DEPTH) |=> eventFlags[ST_FULL])
		else $error("full flag missing");
	a_diag_follow: assert property (@(posedge clk_sys) disable iff (reset)
		$changed(cfgReg[CFG_DIAG]) |=> (diagRoute == $past(cfgReg[CFG_DIAG])))
		else $error("diagnostic route lagging");
endmodule // daqsc_top
`default_nettype wire

/* rtl/daqsc_pkg.sv */
/*
  Constants, field positions, timing counts and state codes for the
  data acquisition sequencer and calibration control block.
  Assumes a single 10 MHz system clock and a 5-bit, 16-bit-data register port.
*/
`default_nettype none
package daqsc_pkg;
	// Clock and acquisition timing
	localparam int CLK_NS = 100;
	localparam int ACQ_MIN_NS = 1500;
	localparam int ACQ_MAX_NS = 6500;
	localparam logic [6:0] ACQ_MIN_CYC = 7'((ACQ_MIN_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [6:0] ACQ_MAX_CYC = 7'(ACQ_MAX_NS / CLK_NS);
	localparam logic [6:0] ACQ_STEP_CYC = 7'h04;
	// Successive approximation pacing
	localparam logic [3:0] TOP_BIT = 4'hC;
	localparam logic [3:0] LOW_BIT_HI = 4'h0;
	localparam logic [3:0] LOW_BIT_LO = 4'h4;
	localparam logic [6:0] TRIAL_CYC_HI = 7'h06;
	localparam logic [6:0] TRIAL_CYC_LO = 7'h04;
	// Calibration averaging and coefficient count
	localparam logic [2:0] CAL_AVG_LAST = 3'h7;
	localparam int LIN_CNT = 13;
	// Result store and instruction store
	localparam logic [5:0] FIFO_DEPTH = 6'h20;
	localparam logic [5:0] THRESH_RESET = 6'h20;
	localparam logic [2:0] LAST_INSTR = 3'h7;
	// Register word indices (address bits 4 to 1)
	localparam logic [3:0] W_CONFIG = 4'h8;
	localparam logic [3:0] W_STATUS = 4'h9;
	localparam logic [3:0] W_FIFOCTL = 4'hA;
	localparam logic [3:0] W_FIFODATA = 4'hB;
	localparam logic [3:0] W_OFFSET = 4'hC;
	// Configuration fields
	localparam int CFG_START = 0;
	localparam int CFG_RESET = 1;
	localparam int CFG_OFFCAL = 2;
	localparam int CFG_FULLCAL = 3;
	localparam int CFG_PTR_LO = 8;
	localparam int CFG_DIAG = 11;
	localparam logic [15:0] CFG_MASK = 16'h0B0D;
	localparam logic [15:0] CFG_RESET_VAL = 16'h0000;
	// Instruction section 0 and limit section fields
	localparam int I_LOOP = 0;
	localparam int I_PAUSE = 1;
	localparam int I_POS_LO = 2;
	localparam int I_NEG_LO = 5;
	localparam int I_RES8 = 10;
	localparam int I_WDOG = 11;
	localparam int I_ACQ_LO = 12;
	localparam int LIM_SIGN = 8;
	localparam int LIM_DIR = 9;
	// Status flag positions
	localparam int ST_LIM1 = 0;
	localparam int ST_LIM2 = 1;
	localparam int ST_FULL = 2;
	localparam int ST_THRESH = 3;
	localparam int ST_PAUSE = 4;
	localparam int ST_CALDONE = 5;
	// Calibration pattern store: bit 7 offset step, bit 6 end, bits 3:0 capacitor
	localparam int ROM_OFF = 7;
	localparam int ROM_END = 6;
	localparam logic [7:0] CAL_ROM [0:15] = '{8'h80, 8'h0C, 8'h0B, 8'h0A, 8'h09, 8'h08, 8'h07,
		8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01, 8'h00, 8'h40, 8'h40};
	// Sequencer states
	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_ACQ = 6'h02,
		S_SAR = 6'h04,
		S_ALU = 6'h08,
		S_STORE = 6'h10,
		S_CALSTEP = 6'h20
	} daqsc_state_t;
endpackage
`default_nettype wire

/* verif/daqsc_afe_model.sv */
/*
  Comparator and analog input model at the converter front end.
  Assumes dacCode is an offset-binary trial code and compIn is sampled while held.
*/
`timescale 1ns/1ps
`default_nettype none
module daqsc_afe_model
(
	// Clock
	input wire logic clk_sys,
	// Front end
	input wire logic [12:0] dacCode,
	input wire logic shHold,
	input wire logic [2:0] muxPos,
	input wire logic calActive,
	output logic compIn
);
	// Channel 1 sits high, channel 2 low, others and calibration at zero
	logic signed [12:0] level;
	// Trial code seen as a signed level
	logic signed [12:0] trialLevel;
	// Free-running toggle shown while tracking
	logic toggle_reg = 1'b0;
	assign level = calActive ? 13'sh0000 : (muxPos == 3'h1) ? 13'sh03E8 :
		(muxPos == 3'h2) ? -13'sh03E8 : 13'sh0000;
	assign trialLevel = {~dacCode[12], dacCode[11:0]};
	// Toggle so a stale level is never seen outside hold
	always @(posedge clk_sys)
		toggle_reg <= ~toggle_reg;
	// Comparator settles in the cycle the trial code is shown
	assign compIn = shHold ? (level > trialLevel) : toggle_reg;
endmodule // daqsc_afe_model
`default_nettype wire

/* verif/daqsc_top_tb_top.sv */
/*
  Register-level testbench of the sequencer and calibration block.
  Assumes the comparator model drives compIn and a 10 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module daqsc_top_tb_top
	import daqsc_pkg::*;
;
	// Register addresses
	localparam logic [4:0] A_CFG = {W_CONFIG, 1'b0};
	localparam logic [4:0] A_ST = {W_STATUS, 1'b0};
	localparam logic [4:0] A_FCTL = {W_FIFOCTL, 1'b0};
	localparam logic [4:0] A_FDAT = {W_FIFODATA, 1'b0};
	// Driven inputs
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [4:0] regAddr = 5'h00;
	logic [15:0] regWrData = 16'h0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic busWidth = 1'b0;
	// Observed outputs
	logic [15:0] regRdData;
	logic compIn, shHold, diagRoute, calActive, calOffsetSel;
	logic [12:0] dacCode;
	logic [2:0] muxPos, muxNeg;
	logic [3:0] calCapSel;
	logic [5:0] eventFlags;
	// Counters and measurements
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;
	int cntHi = 0, cntLo = 0, lastHi = 0, lastLo = 0, h12 = 0, i;
	logic [15:0] capSeen = 16'h0000;
	logic [15:0] d;
	// Device and front end
	daqsc_top daqsc_top_i (.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .bus_width_select(busWidth), .compIn(compIn),
		.dacCode(dacCode), .shHold(shHold), .muxPos(muxPos), .muxNeg(muxNeg), .diagRoute(diagRoute),
		.calActive(calActive), .calOffsetSel(calOffsetSel), .calCapSel(calCapSel), .eventFlags(eventFlags));
	daqsc_afe_model daqsc_afe_model_i (.clk_sys(clk_sys), .dacCode(dacCode), .shHold(shHold),
		.muxPos(muxPos), .calActive(calActive), .compIn(compIn));
	// Clock
	initial forever #50 clk_sys = ~clk_sys;
	// Timeout, hold and acquisition lengths, calibration steps seen
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			bad_count++;
			close_out();
		end
		if (shHold)
		begin
			cntHi++;
			if (cntLo != 0) lastLo = cntLo;
			cntLo = 0;
		end
		else
		begin
			cntLo++;
			if (cntHi != 0) lastHi = cntHi;
			cntHi = 0;
		end
		if (calActive === 1'b1) capSeen[calCapSel] = 1'b1;
		if (calOffsetSel === 1'b1) capSeen[15] = 1'b1;
	end
	// Verdict and end of run
	task close_out();
		if (bad_count == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Compare one value
	task chk(input string n, input logic [15:0] x, input logic [15:0] g);
		num_checks++;
		if (g !== x)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask
	// One-cycle write
	task wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= v;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask
	// One-cycle read, data taken in the following cycle
	task rd(input logic [4:0] a);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask
	// Read and compare
	task rc(input logic [4:0] a, input logic [15:0] x, input string n);
		rd(a);
		chk(n, x, d);
	endtask
	// Instruction section write and check through the pointer
	task wi(input logic [2:0] n, input logic [1:0] s, input logic [15:0] v);
		wr(A_CFG, {6'h00, s, 8'h00});
		wr({1'b0, n, 1'b0}, v);
	endtask
	task ci(input logic [2:0] n, input logic [1:0] s, input logic [15:0] x);
		wr(A_CFG, {6'h00, s, 8'h00});
		rc({1'b0, n, 1'b0}, x, "instr");
	endtask
	// Poll a masked field under a bound
	task poll(input logic [4:0] a, input logic [15:0] m, input logic [15:0] x, input int lim);
		for (int k = 0; k < lim; k++)
		begin
			rd(a);
			if ((d & m) === x) break;
		end
		chk("poll", x, d & m);
	endtask
	// Result pop near an expected signed level
	task near(input logic signed [15:0] e);
		rd(A_FDAT);
		num_checks++;
		if ($isunknown(d) || !(($signed(d) - e) <= 16'sh0004 && (e - $signed(d)) <= 16'sh0004))
		begin
			bad_count++;
			$display("mismatch result expected %h seen %h", e, d);
		end
	endtask
	// Soft reset, clear flags, start
	task run();
		wr(A_CFG, 16'h0002);
		wr(A_ST, 16'h003F);
		wr(A_CFG, 16'h0001);
	endtask
	// Clear start and wait until idle
	task stop();
		wr(A_CFG, 16'h0000);
		poll(A_ST, 16'h0040, 16'h0000, 200);
	endtask
	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		// Values after reset
		rc(A_CFG, CFG_RESET_VAL, "config");
		rc(A_ST, 16'h0000, "status");
		rc(A_FCTL, {10'h000, THRESH_RESET}, "fifoctl");
		// Sections written and read out of order
		wi(3'h1, 2'h0, 16'h0009);
		wi(3'h0, 2'h2, 16'h02AA);
		wi(3'h0, 2'h0, 16'h0004);
		wi(3'h0, 2'h1, 16'h0155);
		wi(3'h0, 2'h3, 16'hFFFF);
		ci(3'h0, 2'h1, 16'h0155);
		ci(3'h1, 2'h0, 16'h0009);
		ci(3'h0, 2'h2, 16'h02AA);
		ci(3'h0, 2'h0, 16'h0004);
		ci(3'h0, 2'h3, 16'h0000);
		wr(5'h1E, 16'hFFFF);
		rc(5'h1E, 16'h0000, "unmapped");
		// 12-bit run with threshold 5, then fill to full
		wr(A_FCTL, 16'h0005);
		run();
		poll(A_FCTL, 16'h3F00, 16'h0500, 400);
		rd(A_ST);
		chk("thresh", 16'h0008, d & 16'h000C);
		h12 = lastHi;
		chk("acq min", 16'h0001, 16'(lastLo >= 15 && lastLo <= 18));
		poll(A_FCTL, 16'h3F00, 16'h2000, 2000);
		rd(A_ST);
		chk("full", 16'h0004, d & 16'h0004);
		stop();
		rc(A_FCTL, 16'h2005, "count");
		for (i = 0; i < 32; i++)
			near(i[0] ? -16'sh03E8 : 16'sh03E8);
		rc(A_FCTL, 16'h0005, "empty");
		// 8-bit run with longest acquisition
		wi(3'h0, 2'h0, 16'hF465);
		run();
		poll(A_FCTL, 16'h3F00, 16'h0300, 800);
		chk("mux", 16'h0019, {10'h000, muxNeg, muxPos});
		stop();
		chk("half time", 16'h0001, 16'(2 * lastHi < h12));
		chk("acq max", 16'h0001, 16'(lastLo >= 65 && lastLo <= 68));
		rd(A_FDAT);
		chk("sign8", 16'h0001, 16'(d[15] === 1'b0 && d != 16'h0000));
		// Monitor: first limit exceeded, second not
		wi(3'h0, 2'h0, 16'h0807);
		wi(3'h0, 2'h1, 16'h021E);
		wi(3'h0, 2'h2, 16'h0264);
		run();
		poll(A_ST, 16'h0013, 16'h0011, 200);
		rc(A_CFG, 16'h0000, "pause start");
		stop();
		chk("flag pins", 16'h0001, {14'h0000, eventFlags[1:0]});
		// Diagnostic routing
		wr(A_CFG, 16'h0800);
		@(posedge clk_sys);
		#1 chk("diag", 16'h0001, {15'h0000, diagRoute});
		wr(A_CFG, 16'h0000);
		// Full calibration then offset only
		capSeen = 16'h0000;
		wr(A_CFG, 16'h0008);
		poll(A_ST, 16'h0020, 16'h0020, 12000);
		chk("caps", 16'hBFFF, capSeen);
		rc(A_CFG, 16'h0000, "cal clear");
		wr(A_ST, 16'h0020);
		capSeen = 16'h0000;
		wr(A_CFG, 16'h0004);
		poll(A_ST, 16'h0020, 16'h0020, 3000);
		chk("offset only", 16'h8001, capSeen);
		// Byte lanes on the narrow bus
		busWidth <= 1'b1;
		repeat (3) @(posedge clk_sys);
		wr(5'h0A, 16'h0034);
		wr(5'h0B, 16'h0012);
		rc(5'h0B, 16'h0012, "high byte");
		rc(5'h0A, 16'h0034, "low byte");
		busWidth <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rc(5'h0A, 16'h1234, "word");
		wr(A_CFG, 16'h0002);
		close_out();
	end
endmodule // daqsc_top_tb_top
`default_nettype wire
